// >>> hdl/parity_err_handler.sv
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
// Notes on behaviour
// [R01] software flushes posted writes with a read
// [R02] check and make parity, fault strobes both sides
// [R03] forward received parity unchanged across the bridge
// [R04] check address parity on every address phase
// [R05] primary address error: withhold claim, flag status
// [R06] primary address error signals system error if enabled
// [R07] secondary address error: withhold claim, flag status
// [R08] secondary address error signals primary system error
// [R09] bad config write: ready, store, fault if enabled
// [R10] bad config write always sets detected bit
// [R11] bad downstream read: secondary fault two clocks later
// [R12] downstream read error status bits by enable
// [R13] return bad downstream data, drop unread prefetch
// [R14] bad upstream read: primary fault, status bits
// [R15] return bad upstream data, drop unread prefetch
// [R16] returned data and parity exactly as received
// [R17] initiator reports bad returned data itself
// [R18] initiator fault during return: no extra action
// [R19] status bits sticky until written with one
module parity_err_handler (
  input wire logic clock_i,
  input wire logic rstn_i,
  // register port
  input wire logic [parity_err_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [parity_err_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [parity_err_pkg::DATA_W-1:0] reg_rdata_o,
  output logic irq_o,
  // primary bus
  input wire logic [31:0] p_ad_i,
  input wire logic [3:0] p_cbe_i,
  input wire logic p_par_i,
  input wire logic p_addr_valid_i,
  input wire logic p_claim_req_i,
  input wire logic p_data_valid_i,
  input wire logic p_read_master_i,
  input wire logic p_cfg0_write_i,
  input wire logic [31:0] p_out_ad_i,
  input wire logic [3:0] p_out_cbe_i,
  output logic p_out_par_o,
  output logic primary_claim_n_o,
  output logic primary_target_ready_n_o,
  output logic primary_parity_fault_n_o,
  output logic primary_parity_fault_oe_n_o,
  output logic primary_system_error_n_o,
  output logic primary_system_error_oe_n_o,
  output logic [31:0] cfg_data_o,
  output logic cfg_store_o,
  // secondary bus
  input wire logic [31:0] s_ad_i,
  input wire logic [3:0] s_cbe_i,
  input wire logic s_par_i,
  input wire logic s_addr_valid_i,
  input wire logic s_claim_req_i,
  input wire logic s_data_valid_i,
  input wire logic s_read_master_i,
  input wire logic [31:0] s_out_ad_i,
  input wire logic [3:0] s_out_cbe_i,
  output logic s_out_par_o,
  output logic secondary_claim_n_o,
  output logic secondary_parity_fault_n_o,
  output logic secondary_parity_fault_oe_n_o,
  // read data forwarded back to each initiator
  input wire logic p_ret_discard_i,
  output logic [31:0] p_ret_ad_o,
  output logic p_ret_par_o,
  output logic p_ret_valid_o,
  input wire logic s_ret_discard_i,
  output logic [31:0] s_ret_ad_o,
  output logic s_ret_par_o,
  output logic s_ret_valid_o
);
  import parity_err_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] mask;
    logic [DATA_W-1:0] rdata;
    logic p_block;
    logic s_block;
    logic [PERR_DELAY-1:0] p_perr;
    logic [PERR_DELAY-1:0] s_perr;
    logic serr;
    logic p_par;
    logic s_par;
    logic [31:0] p_ret_ad;
    logic p_ret_par;
    logic p_ret_valid;
    logic [31:0] s_ret_ad;
    logic s_ret_par;
    logic s_ret_valid;
    logic [31:0] cfg_data;
    logic cfg_stb;
  } state_type;

  state_type q;
  state_type d;

  // even parity over ad, cbe and par: any odd count is an error
  function automatic logic parity_bad(input logic [31:0] ad, input logic [3:0] cbe,
                                      input logic par);
    parity_bad = ^{ad, cbe, par};
  endfunction

  logic pri_per;
  logic sec_per;
  logic serr_en;
  logic p_ape;
  logic s_ape;
  logic p_cfg_pe;
  logic p_rd_pe;
  logic s_rd_pe;
  logic serr_hit;
  logic [STATUS_W-1:0] st_set;
  logic [STATUS_W-1:0] st_clr;

  always_comb begin
    pri_per = q.ctrl[CTRL_PRI_PER];
    sec_per = q.ctrl[CTRL_SEC_PER];
    serr_en = q.ctrl[CTRL_SERR_EN];
    // every address phase is checked, claimed or not
    p_ape = p_addr_valid_i & parity_bad(p_ad_i, p_cbe_i, p_par_i); // [R04] [R02]
    s_ape = s_addr_valid_i & parity_bad(s_ad_i, s_cbe_i, s_par_i); // [R04] [R02]
    p_cfg_pe = p_cfg0_write_i & parity_bad(p_ad_i, p_cbe_i, p_par_i);
    p_rd_pe = p_data_valid_i & p_read_master_i & parity_bad(p_ad_i, p_cbe_i, p_par_i);
    s_rd_pe = s_data_valid_i & s_read_master_i & parity_bad(s_ad_i, s_cbe_i, s_par_i);
    serr_hit = (p_ape & serr_en & pri_per) // [R06]
             | (s_ape & serr_en & sec_per); // [R08]

    st_set = '0;
    st_set[ST_PRI_DETECTED] = p_ape | p_cfg_pe | p_rd_pe; // [R05] [R10] [R14]
    st_set[ST_PRI_DATA_PAR] = p_rd_pe & pri_per; // [R14]
    st_set[ST_PRI_SIG_SERR] = serr_hit; // [R06] [R08]
    st_set[ST_SEC_DETECTED] = s_ape | s_rd_pe; // [R07] [R12]
    st_set[ST_SEC_DATA_PAR] = s_rd_pe & sec_per; // [R12]
    st_clr = (reg_write_i && reg_addr_i == STATUS_ADDR) ? reg_wdata_i[STATUS_W-1:0] : '0;

    d = q;
    // set beats a clear landing in the same cycle
    d.status = (q.status & ~st_clr) | st_set; // [R19]
    if (reg_write_i && reg_addr_i == CTRL_ADDR) begin
      d.ctrl = reg_wdata_i[CTRL_W-1:0];
    end
    if (reg_write_i && reg_addr_i == MASK_ADDR) begin
      d.mask = reg_wdata_i[STATUS_W-1:0];
    end
    d.rdata = '0;
    if (reg_read_i) begin
      case (reg_addr_i)
        CTRL_ADDR: d.rdata = {{(DATA_W-CTRL_W){1'b0}}, q.ctrl};
        STATUS_ADDR: d.rdata = {{(DATA_W-STATUS_W){1'b0}}, q.status};
        MASK_ADDR: d.rdata = {{(DATA_W-STATUS_W){1'b0}}, q.mask};
        default: d.rdata = '0;
      endcase
    end

    // claim veto held from the address phase to the claim
    if (p_addr_valid_i) begin
      d.p_block = p_ape & pri_per; // [R05]
    end
    if (s_addr_valid_i) begin
      d.s_block = s_ape & sec_per; // [R07]
    end

    // two-stage shift puts the fault strobe two clocks after the data phase
    d.p_perr = {q.p_perr[PERR_DELAY-2:0], (p_cfg_pe | p_rd_pe) & pri_per}; // [R09] [R14]
    d.s_perr = {q.s_perr[PERR_DELAY-2:0], s_rd_pe & sec_per}; // [R11]
    d.serr = serr_hit; // [R06] [R08]

    // outgoing parity for data the bridge itself drives, one clock behind
    d.p_par = ^{p_out_ad_i, p_out_cbe_i}; // [R02]
    d.s_par = ^{s_out_ad_i, s_out_cbe_i}; // [R02]

    // read data goes back with the parity it came with, never regenerated
    d.p_ret_valid = s_data_valid_i & s_read_master_i; // [R13]
    if (s_data_valid_i && s_read_master_i) begin
      d.p_ret_ad = s_ad_i; // [R16] [R03]
      d.p_ret_par = s_par_i; // [R16] [R03]
    end
    d.s_ret_valid = p_data_valid_i & p_read_master_i; // [R15]
    if (p_data_valid_i && p_read_master_i) begin
      d.s_ret_ad = p_ad_i; // [R16] [R03]
      d.s_ret_par = p_par_i; // [R16] [R03]
    end

    // bad config data is still stored
    d.cfg_stb = p_cfg0_write_i; // [R09]
    if (p_cfg0_write_i) begin
      d.cfg_data = p_ad_i; // [R09]
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.status <= STATUS_RESET;
      q.mask <= MASK_RESET;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign irq_o = |(q.status & q.mask);
  assign primary_claim_n_o = !(p_claim_req_i && !q.p_block); // [R05]
  assign secondary_claim_n_o = !(s_claim_req_i && !q.s_block); // [R07]
  // config write completes in its single data phase whatever the parity
  assign primary_target_ready_n_o = !p_cfg0_write_i; // [R09]
  assign primary_parity_fault_n_o = !q.p_perr[PERR_DELAY-1];
  assign primary_parity_fault_oe_n_o = !q.p_perr[PERR_DELAY-1];
  assign secondary_parity_fault_n_o = !q.s_perr[PERR_DELAY-1];
  assign secondary_parity_fault_oe_n_o = !q.s_perr[PERR_DELAY-1];
  // open drain: only ever driven low
  assign primary_system_error_n_o = !q.serr;
  assign primary_system_error_oe_n_o = !q.serr;
  assign p_out_par_o = q.p_par;
  assign s_out_par_o = q.s_par;
  assign cfg_data_o = q.cfg_data;
  assign cfg_store_o = q.cfg_stb;
  // unread prefetch is dropped rather than handed on; an initiator fault
  // strobe during return is not watched, the initiator owns that error
  assign p_ret_ad_o = q.p_ret_ad;
  assign p_ret_par_o = q.p_ret_par;
  assign p_ret_valid_o = q.p_ret_valid & !p_ret_discard_i; // [R13] [R18] [R17]
  assign s_ret_ad_o = q.s_ret_ad;
  assign s_ret_par_o = q.s_ret_par;
  assign s_ret_valid_o = q.s_ret_valid & !s_ret_discard_i; // [R15] [R18] [R17]
endmodule

// >>> inc/parity_err_pkg.sv
package parity_err_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] MASK_ADDR = 8'h08;
  // control bits
  localparam int CTRL_PRI_PER = 0;
  localparam int CTRL_SERR_EN = 1;
  localparam int CTRL_SEC_PER = 2;
  localparam int CTRL_W = 3;
  // status bits
  localparam int ST_PRI_DETECTED = 0;
  localparam int ST_PRI_DATA_PAR = 1;
  localparam int ST_PRI_SIG_SERR = 2;
  localparam int ST_SEC_DETECTED = 3;
  localparam int ST_SEC_DATA_PAR = 4;
  localparam int STATUS_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h00;
  localparam logic [STATUS_W-1:0] MASK_RESET = 5'h00;
  // data phase to fault strobe, in clocks
  localparam int PERR_DELAY = 2;
endpackage

// >>> sim/parity_err_sva.sv
`timescale 1ns/10ps
module parity_err_sva (
  input wire logic clock_i, rstn_i, reg_write_i, p_par_i, s_par_i, p_addr_valid_i,
  input wire logic s_addr_valid_i, p_claim_req_i, s_claim_req_i, p_cfg0_write_i,
  input wire logic p_data_valid_i, p_read_master_i, s_data_valid_i, s_read_master_i,
  input wire logic primary_claim_n_o, secondary_claim_n_o, primary_system_error_n_o,
  input wire logic primary_parity_fault_n_o, secondary_parity_fault_n_o, cfg_store_o,
  input wire logic p_ret_discard_i, p_ret_par_o, p_ret_valid_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [3:0] p_cbe_i, s_cbe_i,
  input wire logic [31:0] reg_wdata_i, p_ad_i, s_ad_i, cfg_data_o, p_ret_ad_o
);
  import parity_err_pkg::*;
  logic [2:0] c_q;
  logic pb, sb;
  assign pb = ^{p_ad_i, p_cbe_i, p_par_i};
  assign sb = ^{s_ad_i, s_cbe_i, s_par_i};
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) c_q <= CTRL_RESET;
    else if (reg_write_i && reg_addr_i == CTRL_ADDR) c_q <= reg_wdata_i[2:0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  serr_pulse_a: assert property (p_addr_valid_i && pb && c_q[0] && c_q[1]
    |=> !primary_system_error_n_o ##1 primary_system_error_n_o) else $error("serr pulse");
  serr_cause_a: assert property (!primary_system_error_n_o |-> $past(
    (p_addr_valid_i && pb && c_q[0] && c_q[1]) || (s_addr_valid_i && sb && c_q[1] && c_q[2])))
    else $error("serr cause");
  pri_veto_a: assert property (p_addr_valid_i && pb ##1 p_claim_req_i
    |-> primary_claim_n_o == $past(c_q[0])) else $error("primary claim");
  sec_veto_a: assert property (s_addr_valid_i && sb ##1 s_claim_req_i
    |-> secondary_claim_n_o == $past(c_q[2])) else $error("secondary claim");
  pri_fault_a: assert property ((p_cfg0_write_i || p_data_valid_i && p_read_master_i)
    && pb |-> ##2 primary_parity_fault_n_o != $past(c_q[0], 2)) else $error("primary fault");
  sec_fault_a: assert property (s_data_valid_i && s_read_master_i && sb
    |-> ##2 secondary_parity_fault_n_o != $past(c_q[2], 2)) else $error("secondary fault");
  cfg_store_a: assert property (p_cfg0_write_i
    |=> cfg_store_o && cfg_data_o == $past(p_ad_i)) else $error("config store");
  ret_fwd_a: assert property (s_data_valid_i && s_read_master_i |=>
    p_ret_ad_o == $past(s_ad_i) && p_ret_par_o == $past(s_par_i)
    && p_ret_valid_o == !p_ret_discard_i) else $error("read forward");
  cover property (p_addr_valid_i && pb ##1 !primary_system_error_n_o);
  cover property (p_cfg0_write_i && pb && c_q[0]);
  cover property (s_data_valid_i && s_read_master_i && sb && c_q[2]);
endmodule
bind parity_err_handler parity_err_sva u_parity_err_sva (.*);

// >>> sim/pci_agent.sv
`timescale 1ns/10ps
module pci_agent (
  input wire logic clock_i,
  input wire logic bad_i,
  input wire logic ret_valid_i,
  input wire logic ret_par_i,
  input wire logic [31:0] word_i,
  input wire logic [31:0] ret_ad_i,
  output logic [31:0] ad_o,
  output logic [3:0] cbe_o,
  output logic par_o,
  output logic perr_n_o
);
  logic [1:0] hit_q;
  // all lanes enabled, so parity covers ad alone
  assign cbe_o = 4'h0;
  assign ad_o = word_i;
  assign par_o = ^word_i ^ bad_i;
  // initiator owns its read errors; the bridge must not react
  always_ff @(posedge clock_i) begin
    hit_q <= {hit_q[0], ret_valid_i & ^{ret_ad_i, ret_par_i}};
  end
  assign perr_n_o = !hit_q[1];
endmodule

// >>> sim/tb.sv
`timescale 1ns/10ps
module tb;
  import parity_err_pkg::*;
  logic clock_i = 1'b0, rstn_i = 1'b0, reg_write_i = 1'b0, reg_read_i = 1'b0;
  logic p_claim_req_i = 1'b0, s_claim_req_i = 1'b0, p_ret_discard_i = 1'b0, s_ret_discard_i;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, word = 32'h0, p_ad_i, s_ad_i, p_out_ad_i, s_out_ad_i;
  logic [4:0] st = 5'h00, e;
  logic [3:0] p_cbe_i, s_cbe_i;
  logic p_par_i, s_par_i, p_addr_valid_i, s_addr_valid_i, p_data_valid_i, s_data_valid_i;
  logic p_read_master_i, s_read_master_i, p_cfg0_write_i, bad = 1'b0;
  logic [31:0] reg_rdata_o, cfg_data_o, p_ret_ad_o, s_ret_ad_o;
  logic irq_o, p_out_par_o, primary_claim_n_o, primary_target_ready_n_o, primary_parity_fault_n_o;
  logic primary_parity_fault_oe_n_o, primary_system_error_n_o, primary_system_error_oe_n_o;
  logic cfg_store_o, s_out_par_o, secondary_claim_n_o, secondary_parity_fault_n_o;
  logic secondary_parity_fault_oe_n_o, p_ret_par_o, p_ret_valid_o, s_ret_par_o, s_ret_valid_o;
  int miscompares = 0, n_compared = 0;
  assign {s_ad_i, s_cbe_i, s_par_i} = {p_ad_i, p_cbe_i, p_par_i};
  assign {p_data_valid_i, p_read_master_i, s_data_valid_i, s_read_master_i} = {{2{st[4]}}, {2{st[3]}}};
  assign {p_cfg0_write_i, s_addr_valid_i, p_addr_valid_i} = st[2:0];
  assign {p_out_ad_i, s_out_ad_i, s_ret_discard_i} = {word, ~word, p_ret_discard_i};
  parity_err_handler u_parity_err_handler (.*, .p_out_cbe_i(4'h0), .s_out_cbe_i(4'h7));
  pci_agent u_pci_agent (.clock_i, .bad_i(bad), .ret_valid_i(p_ret_valid_o),
    .ret_par_i(p_ret_par_o), .word_i(word), .ret_ad_i(p_ret_ad_o), .ad_o(p_ad_i),
    .cbe_o(p_cbe_i), .par_o(p_par_i), .perr_n_o());
  always #50 clock_i = ~clock_i;
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    {reg_write_i, reg_read_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
    @(posedge clock_i);
    {reg_write_i, reg_read_i} <= 2'b00;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(reg_rdata_o, x);
  endtask
  task automatic ev(input int k);
    @(posedge clock_i);
    {st, p_claim_req_i, s_claim_req_i} <= {5'h01 << k, 2'b00};
    #1 if (k == 2) chk(primary_target_ready_n_o, 0);
    @(posedge clock_i);
    {st, p_claim_req_i, s_claim_req_i} <= 7'h03;
    #1;
  endtask
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    for (int a = 0; a < 16; a += 4) rd(a[7:0], 0);
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 8; c++) begin
        bus(1'b1, CTRL_ADDR, c);
        bus(1'b1, MASK_ADDR, 32'h1b);
        rd(CTRL_ADDR, c);
        @(posedge clock_i);
        {p_ret_discard_i, bad, word} <= {c[0], b[0], 32'h5a3c_0f00 + c};
        for (int k = 0; k < 5; k++) begin
          bus(1'b1, STATUS_ADDR, 32'h1f);
          e = {k == 3 && c[2], k == 1 || k == 3, (k == 0 && c[0] && c[1]) ||
            (k == 1 && c[1] && c[2]), k == 4 && c[0], k == 0 || k == 2 || k == 4};
          e = e & {5{b[0]}};
          ev(k);
          if (k < 2) chk(k ? secondary_claim_n_o : primary_claim_n_o, b & c[2 * k]);
          if (k > 2) chk(k == 3 ? p_ret_ad_o : s_ret_ad_o, word);
          if (k > 2) chk(k == 3 ? {p_ret_valid_o, p_ret_par_o} : {s_ret_valid_o, s_ret_par_o},
            {~c[0], ^word ^ b[0]});
          chk({primary_system_error_n_o, primary_system_error_oe_n_o}, {2{!e[2]}});
          chk({p_out_par_o, s_out_par_o}, {^word, !(^word)});
          // fault strobe stands only in the second cycle after the data phase
          @(posedge clock_i);
          #1 chk({primary_parity_fault_n_o, primary_parity_fault_oe_n_o, secondary_parity_fault_n_o,
            secondary_parity_fault_oe_n_o}, {{2{!(b[0] && c[0] && (k == 2 || k == 4))}},
            {2{!e[4]}}});
          rd(STATUS_ADDR, e);
          chk(irq_o, |(e & 5'h1b));
          bus(1'b1, STATUS_ADDR, 32'h0);
          rd(STATUS_ADDR, e);
        end
        $display("test bad %0d ctrl %0d done", b, c);
      end
    end
    bus(1'b1, STATUS_ADDR, 32'h1f);
    rd(STATUS_ADDR, 0);
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    complete_run;
  end
endmodule
